/* rtl/tlbm_pkg.sv */
package tlbm_pkg;
    // entry array geometry
    localparam int ENTRIES = 8;
    localparam int IDX_W = 3;
    localparam int VA_W = 20;
    localparam int ASID_W = 8;
    // operand fields of the written word
    localparam int VA_LSB = 12;
    localparam int ASID_LSB = 0;
    // minor register field encodings
    localparam logic [3:0] CRM_INNER = 4'h3;
    localparam logic [3:0] CRM_INSN = 4'h5;
    localparam logic [3:0] CRM_DATA = 4'h6;
    localparam logic [3:0] CRM_UNIFIED = 4'h7;
    // operation select encodings
    localparam logic [2:0] OP_ALL = 3'h0;
    localparam logic [2:0] OP_ADDR_ASID = 3'h1;
    localparam logic [2:0] OP_ASID = 3'h2;
    localparam logic [2:0] OP_ADDR_ALL = 3'h3;
    // return link lies one instruction past the command
    localparam logic [31:0] RET_OFS = 32'h0000_0004;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
    // reset values
    localparam logic [31:0] LINK_RST = 32'h0000_0000;
    localparam logic [ASID_W-1:0] ASID_RST = 8'h00;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_ALL,
        CMD_ADDR_ASID,
        CMD_ASID,
        CMD_ADDR_ALL
    } tlbm_cmd_t;
endpackage : tlbm_pkg

/* rtl/tlbm_sweep.sv */
`timescale 1ns/1ps
module tlbm_sweep
    import tlbm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    output logic [tlbm_pkg::IDX_W-1:0] idx,
    output logic last
);
    logic [IDX_W-1:0] idx_r;
    logic [IDX_W-1:0] idx_nxt;

    // step one entry per cycle while running, park at zero otherwise
    assign idx_nxt = run ? idx_r + 3'h1 : 3'h0;
    assign idx = idx_r;
    assign last = run && (idx_r == IDX_LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_r <= 3'h0;
        end else if (ce) begin
            idx_r <= idx_nxt;
        end
    end
endmodule : tlbm_sweep

/* rtl/tlbm_top.sv */
`timescale 1ns/1ps
module tlbm_top (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic CP_VALID,
    input wire logic CP_READ,
    input wire logic CP_PRIV,
    input wire logic [3:0] CP_MINOR,
    input wire logic [2:0] CP_OPSEL,
    input wire logic [31:0] CP_DATA,
    input wire logic [31:0] CP_PC,
    input wire logic IRQ_REQ,
    input wire logic FILL_VALID,
    input wire logic [tlbm_pkg::IDX_W-1:0] FILL_IDX,
    input wire logic [tlbm_pkg::VA_W-1:0] FILL_VA,
    input wire logic [tlbm_pkg::ASID_W-1:0] FILL_ASID,
    input wire logic FILL_GLOBAL,
    input wire logic FILL_LOCK,
    input wire logic [tlbm_pkg::VA_W-1:0] LOOKUP_VA,
    input wire logic [tlbm_pkg::ASID_W-1:0] LOOKUP_ASID,
    output logic LOOKUP_HIT,
    output logic STALL,
    output logic DONE,
    output logic UNDEF,
    output logic ABORT,
    output logic BCAST,
    output logic [31:0] RET_LINK
);
    import tlbm_pkg::*;

    typedef enum logic {ST_IDLE, ST_SWEEP} tlbm_state_t;

    tlbm_state_t state_r;
    tlbm_state_t state_nxt;
    logic [ENTRIES-1:0] valid_r;
    logic [ENTRIES-1:0] valid_nxt;
    logic [ENTRIES-1:0] glob_r;
    logic [ENTRIES-1:0] lock_r;
    logic [VA_W-1:0] va_r [ENTRIES];
    logic [ASID_W-1:0] asid_r [ENTRIES];
    logic [ASID_W-1:0] sweep_asid_r;
    logic [31:0] pc_r;
    logic [31:0] link_r;
    logic hit_r, done_r, undef_r, abort_r, bcast_r, stall_r;

    // match vector over all entries; ASID compare optional, globals always qualify
    function automatic logic [ENTRIES-1:0] hit_vec(input logic [VA_W-1:0] va,
                                                   input logic [ASID_W-1:0] asid,
                                                   input logic use_asid);
        logic [ENTRIES-1:0] v;
        v = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            v[i] = valid_r[i] && (va_r[i] == va) && (!use_asid || glob_r[i] || asid_r[i] == asid);
        end
        return v;
    endfunction : hit_vec

    // operand fields and request qualification
    wire logic [VA_W-1:0] op_va = CP_DATA[VA_LSB +: VA_W];
    wire logic [ASID_W-1:0] op_asid = CP_DATA[ASID_LSB +: ASID_W];
    wire logic req = CP_VALID && !stall_r;
    wire logic bad_acc = req && (CP_READ || !CP_PRIV);
    wire logic wr_ok = req && !CP_READ && CP_PRIV;
    wire logic minor_inner = (CP_MINOR == CRM_INNER);
    wire logic minor_local = (CP_MINOR == CRM_INSN) || (CP_MINOR == CRM_DATA) || (CP_MINOR == CRM_UNIFIED);
    wire logic op_known = wr_ok && (minor_inner || minor_local) && (CP_OPSEL <= OP_ADDR_ALL);

    tlbm_cmd_t cmd;
    always_comb begin
        cmd = CMD_NONE;
        if (op_known) begin
            case (CP_OPSEL)
                OP_ALL: cmd = CMD_ALL;
                OP_ADDR_ASID: cmd = CMD_ADDR_ASID;
                OP_ASID: cmd = CMD_ASID;
                OP_ADDR_ALL: cmd = CMD_ADDR_ALL;
                default: cmd = CMD_NONE;
            endcase
        end
    end

    wire logic [IDX_W-1:0] sweep_idx;
    wire logic sweep_last;
    wire logic sweeping = (state_r == ST_SWEEP);
    wire logic irq_abort = sweeping && IRQ_REQ;
    logic [ENTRIES-1:0] addr_asid_hit;
    logic [ENTRIES-1:0] addr_any_hit;
    logic [ENTRIES-1:0] look_hit;

    // match vectors; a process, so entry updates retrigger the compare too
    always_comb begin
        addr_asid_hit = hit_vec(op_va, op_asid, 1'b1);
        addr_any_hit = hit_vec(op_va, op_asid, 1'b0);
        look_hit = hit_vec(LOOKUP_VA, LOOKUP_ASID, 1'b1);
    end
    wire logic fill_ok = FILL_VALID && !stall_r && !CP_VALID;

    tlbm_sweep u_sweep (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .run(sweeping && !IRQ_REQ),
        .idx(sweep_idx),
        .last(sweep_last)
    );

    // valid bits after this cycle's command
    always_comb begin
        valid_nxt = valid_r;
        case (cmd)
            CMD_ALL: valid_nxt = valid_r & lock_r;
            CMD_ADDR_ASID: valid_nxt = valid_r & ~addr_asid_hit;
            CMD_ADDR_ALL: valid_nxt = valid_r & ~addr_any_hit;
            default: valid_nxt = valid_r;
        endcase
        if (sweeping && !IRQ_REQ && !glob_r[sweep_idx] && asid_r[sweep_idx] == sweep_asid_r) begin
            valid_nxt[sweep_idx] = 1'b0;
        end
        if (fill_ok) begin
            valid_nxt[FILL_IDX] = 1'b1;
        end
    end

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: state_nxt = (cmd == CMD_ASID) ? ST_SWEEP : ST_IDLE;
            ST_SWEEP: state_nxt = (IRQ_REQ || sweep_last) ? ST_IDLE : ST_SWEEP;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // entry valid bits and sequencer
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            valid_r <= '0;
            state_r <= ST_IDLE;
        end else if (CE) begin
            valid_r <= valid_nxt;
            state_r <= state_nxt;
        end
    end

    // entry payload, written by fills
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            glob_r <= '0;
            lock_r <= '0;
            for (int i = 0; i < ENTRIES; i++) begin
                va_r[i] <= '0;
                asid_r[i] <= ASID_RST;
            end
        end else if (CE && fill_ok) begin
            glob_r[FILL_IDX] <= FILL_GLOBAL;
            lock_r[FILL_IDX] <= FILL_LOCK;
            va_r[FILL_IDX] <= FILL_VA;
            asid_r[FILL_IDX] <= FILL_ASID;
        end
    end

    // sweep operands captured with the command
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sweep_asid_r <= ASID_RST;
            pc_r <= LINK_RST;
        end else if (CE && cmd == CMD_ASID) begin
            sweep_asid_r <= op_asid;
            pc_r <= CP_PC;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            stall_r <= 1'b0;
        end else if (CE) begin
            stall_r <= (state_nxt == ST_SWEEP);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            link_r <= LINK_RST;
        end else if (CE && irq_abort) begin
            link_r <= pc_r + RET_OFS;
        end
    end

    // answer pulses and lookup result
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            hit_r <= 1'b0;
            done_r <= 1'b0;
            undef_r <= 1'b0;
            abort_r <= 1'b0;
            bcast_r <= 1'b0;
        end else if (CE) begin
            hit_r <= |look_hit;
            done_r <= (op_known && cmd != CMD_ASID) || (sweep_last && !IRQ_REQ);
            undef_r <= bad_acc;
            abort_r <= irq_abort;
            bcast_r <= op_known && minor_inner;
        end
    end

    assign LOOKUP_HIT = hit_r;
    assign STALL = stall_r;
    assign DONE = done_r;
    assign UNDEF = undef_r;
    assign ABORT = abort_r;
    assign BCAST = bcast_r;
    assign RET_LINK = link_r;

    // helper: length of the current stall
    logic [3:0] stall_cnt_r;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            stall_cnt_r <= 4'h0;
        end else if (CE) begin
            stall_cnt_r <= stall_r ? stall_cnt_r + 4'h1 : 4'h0;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    undef_on_read_a: assert property (CE && bad_acc |=> UNDEF)
        else $error("illegal access did not trap");
    priv_write_a: assert property (CE && wr_ok |=> !UNDEF)
        else $error("privileged write trapped");
    all_keeps_lock_a: assert property (CE && cmd == CMD_ALL |=> valid_r == $past(valid_r & lock_r))
        else $error("invalidate all wrong");
    addr_asid_clear_a: assert property (CE && cmd == CMD_ADDR_ASID |=> (valid_r & $past(addr_asid_hit)) == '0)
        else $error("address entry survived");
    addr_all_clear_a: assert property (CE && cmd == CMD_ADDR_ALL |=> (valid_r & $past(addr_any_hit)) == '0)
        else $error("address-all entry survived");
    sweep_keeps_glob_a: assert property (CE && sweeping |=> (valid_r & $past(valid_r & glob_r)) == $past(valid_r & glob_r))
        else $error("global entry cleared");
    abort_link_a: assert property (CE && irq_abort |=> ABORT && RET_LINK == pc_r + RET_OFS && !STALL)
        else $error("abort link wrong");
    stall_bound_a: assert property (stall_cnt_r <= 4'h8)
        else $error("stall too long");
    sweep_stall_a: assert property (CE && cmd == CMD_ASID |=> STALL)
        else $error("asid command did not stall");
    side_alias_a: assert property (CE && op_known && minor_local |=> DONE || STALL)
        else $error("local form not executed");
    bcast_inner_a: assert property (CE && op_known && minor_inner |=> BCAST)
        else $error("inner form not broadcast");

    sweep_done_c: cover property (CE && sweep_last && !IRQ_REQ);
    sweep_abort_c: cover property (CE && irq_abort);
    undef_c: cover property (UNDEF);
    all_c: cover property (CE && cmd == CMD_ALL && |lock_r);
endmodule : tlbm_top

/* tb/tlbm_cpu.sv */
`timescale 1ns/1ps
// pipeline side model: issues coprocessor accesses to the command port
module tlbm_cpu (
    input wire logic clk,
    output logic cp_valid,
    output logic cp_read,
    output logic cp_priv,
    output logic [3:0] cp_minor,
    output logic [2:0] cp_opsel,
    output logic [31:0] cp_data,
    output logic [31:0] cp_pc
);
    // idle state at time zero
    initial begin
        cp_valid = 1'b0;
        cp_read = 1'b0;
        cp_priv = 1'b0;
        cp_minor = 4'h0;
        cp_opsel = 3'h0;
        cp_data = 32'h0000_0000;
        cp_pc = 32'h0000_0000;
    end
    // one access held over its taking edge, data and pc scrambled after release
    task automatic issue(input logic rd, input logic pv, input logic [3:0] mn, input logic [2:0] op,
            input logic [31:0] dt, input logic [31:0] pc);
        @(negedge clk);
        cp_valid = 1'b1;
        cp_read = rd;
        cp_priv = pv;
        cp_minor = mn;
        cp_opsel = op;
        cp_data = dt;
        cp_pc = pc;
        @(negedge clk);
        cp_valid = 1'b0;
        cp_data = ~dt;
        cp_pc = ~pc;
    endtask : issue
endmodule : tlbm_cpu

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import tlbm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic irq_req = 1'b0;
    logic ce = 1'b1;
    logic fill_valid = 1'b0;
    logic [IDX_W-1:0] fill_idx = 3'h0;
    logic [VA_W-1:0] fill_va = 20'h00000;
    logic [ASID_W-1:0] fill_asid = 8'h00;
    logic fill_global = 1'b0;
    logic fill_lock = 1'b0;
    logic [VA_W-1:0] lookup_va = 20'h00000;
    logic [ASID_W-1:0] lookup_asid = 8'h00;
    logic cp_valid, cp_read, cp_priv, hit, stall, done, undef, abrt, bcast;
    logic [3:0] cp_minor;
    logic [2:0] cp_opsel;
    logic [31:0] cp_data, cp_pc, ret_link;
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    // free-running core clock, 40 ns period
    always #20 clk_sys = ~clk_sys;
    tlbm_cpu i_cpu (.clk(clk_sys), .cp_valid(cp_valid), .cp_read(cp_read), .cp_priv(cp_priv),
        .cp_minor(cp_minor), .cp_opsel(cp_opsel), .cp_data(cp_data), .cp_pc(cp_pc));
    tlbm_top i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .CP_VALID(cp_valid), .CP_READ(cp_read),
        .CP_PRIV(cp_priv), .CP_MINOR(cp_minor), .CP_OPSEL(cp_opsel), .CP_DATA(cp_data), .CP_PC(cp_pc),
        .IRQ_REQ(irq_req), .FILL_VALID(fill_valid), .FILL_IDX(fill_idx), .FILL_VA(fill_va),
        .FILL_ASID(fill_asid), .FILL_GLOBAL(fill_global), .FILL_LOCK(fill_lock), .LOOKUP_VA(lookup_va),
        .LOOKUP_ASID(lookup_asid), .LOOKUP_HIT(hit), .STALL(stall), .DONE(done), .UNDEF(undef),
        .ABORT(abrt), .BCAST(bcast), .RET_LINK(ret_link));
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic fill(input logic [2:0] ix, input logic [19:0] va, input logic [7:0] as,
            input logic gl, input logic lk);
        @(negedge clk_sys);
        fill_valid = 1'b1;
        fill_idx = ix;
        fill_va = va;
        fill_asid = as;
        fill_global = gl;
        fill_lock = lk;
        @(negedge clk_sys);
        fill_valid = 1'b0;
    endtask : fill
    task automatic probe(input logic [19:0] va, input logic [7:0] as, input logic exp);
        @(negedge clk_sys);
        lookup_va = va;
        lookup_asid = as;
        @(negedge clk_sys);
        chk(hit, exp, "lookup");
    endtask : probe
    task automatic op(input logic [3:0] mn, input logic [2:0] o, input logic [31:0] d);
        i_cpu.issue(1'b0, 1'b1, mn, o, d, 32'h0000_1230);
    endtask : op
    // bounded wait for the end of an ASID sweep, counting cycles
    task automatic wait_done();
        while (done !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        if (done !== 1'b1) begin
            chk(1'b1, 1'b0, "sweep hung");
            close_out();
        end
    endtask : wait_done
    task automatic sc_access();
        i_cpu.issue(1'b1, 1'b1, CRM_UNIFIED, OP_ALL, 32'h0000_0000, 32'h0000_0000);
        chk(undef, 1'b1, "read trap");
        i_cpu.issue(1'b0, 1'b0, CRM_UNIFIED, OP_ALL, 32'h0000_0000, 32'h0000_0000);
        chk({done, undef}, 2'h1, "user write");
        op(4'h4, OP_ALL, 32'h0000_0000);
        chk({done, undef}, 2'h0, "reserved pair");
    endtask : sc_access
    task automatic sc_all(input logic [3:0] mn);
        fill(3'h0, 20'h00011, 8'h05, 1'b0, 1'b0);
        fill(3'h1, 20'h00022, 8'h05, 1'b0, 1'b1);
        op(mn, OP_ALL, 32'h0000_0000);
        chk({done, bcast}, {1'b1, mn == CRM_INNER}, "all done");
        probe(20'h00011, 8'h05, 1'b0);
        probe(20'h00022, 8'h05, 1'b1);
    endtask : sc_all
    task automatic sc_addr(input logic [3:0] mn, input logic [3:0] mn2);
        fill(3'h2, 20'h00033, 8'h07, 1'b0, 1'b1);
        fill(3'h3, 20'h00044, 8'h09, 1'b1, 1'b0);
        fill(3'h4, 20'h00055, 8'h02, 1'b0, 1'b1);
        op(mn, OP_ADDR_ASID, {20'h00033, 12'h007});
        chk(done, 1'b1, "addr done");
        op(mn, OP_ADDR_ASID, {20'h00044, 12'h001});
        op(mn, OP_ADDR_ASID, {20'h00055, 12'h003});
        probe(20'h00033, 8'h07, 1'b0);
        probe(20'h00044, 8'h09, 1'b0);
        probe(20'h00055, 8'h02, 1'b1);
        op(mn2, OP_ADDR_ALL, {20'h00055, 12'h0AA});
        probe(20'h00055, 8'h02, 1'b0);
    endtask : sc_addr
    task automatic sc_asid();
        fill(3'h0, 20'h00011, 8'h0C, 1'b0, 1'b1);
        fill(3'h1, 20'h00022, 8'h0C, 1'b1, 1'b0);
        fill(3'h2, 20'h00033, 8'h0D, 1'b0, 1'b0);
        op(CRM_DATA, OP_ASID, 32'h0000_000C);
        chk(stall, 1'b1, "stall on");
        n = 1;
        wait_done();
        chk(n, 9, "sweep length");
        chk(stall, 1'b0, "stall off");
        probe(20'h00011, 8'h0C, 1'b0);
        probe(20'h00022, 8'h0C, 1'b1);
        probe(20'h00033, 8'h0D, 1'b1);
    endtask : sc_asid
    // clock enable low on the first sweep cycle, before entry 0, freezes the sweep and its stall
    task automatic sc_hold();
        fill(3'h5, 20'h00066, 8'h21, 1'b0, 1'b1);
        op(CRM_UNIFIED, OP_ASID, 32'h0000_0021);
        ce = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk({stall, done}, 2'h2, "frozen sweep");
        ce = 1'b1;
        n = 1;
        wait_done();
        chk(n, 9, "sweep length after hold");
        probe(20'h00066, 8'h21, 1'b0);
    endtask : sc_hold
    task automatic sc_abort();
        fill(3'h0, 20'h00011, 8'h0E, 1'b0, 1'b0);
        op(CRM_INNER, OP_ASID, 32'h0000_000E);
        irq_req = 1'b1;
        @(negedge clk_sys);
        irq_req = 1'b0;
        chk({abrt, stall}, 2'h2, "aborted");
        chk(ret_link, 32'h0000_1230 + RET_OFS, "link");
        fill(3'h6, 20'h00077, 8'h0E, 1'b0, 1'b1);
        op(CRM_INNER, OP_ASID, 32'h0000_000E);
        n = 1;
        wait_done();
        probe(20'h00077, 8'h0E, 1'b0);
        probe(20'h00011, 8'h0E, 1'b0);
    endtask : sc_abort
    // reset for three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        chk(ret_link, LINK_RST, "link reset");
        sc_access();
        sc_all(CRM_INNER);
        sc_all(CRM_UNIFIED);
        sc_addr(CRM_INSN, CRM_DATA);
        sc_addr(CRM_INNER, CRM_UNIFIED);
        sc_asid();
        sc_hold();
        sc_abort();
        close_out();
    end
endmodule : testbench
